/* File: bsf_pkg.sv */
// types and constants of the branch, skip and flow unit
// assumes one core clock; request comes from the decode stage

package bsf_pkg;

	// ==========================================
	// status flag bit positions
	localparam int BSF_FLAG_C = 0;
	localparam int BSF_FLAG_Z = 1;
	localparam int BSF_FLAG_N = 2;
	localparam int BSF_FLAG_V = 3;
	localparam int BSF_FLAG_S = 4;
	localparam int BSF_FLAG_H = 5;
	localparam int BSF_FLAG_T = 6;

	// ==========================================
	// cycle counts per instruction
	localparam logic [1:0] BSF_CYC_ONE   = 2'h1;
	localparam logic [1:0] BSF_CYC_TWO   = 2'h2;
	localparam logic [1:0] BSF_CYC_THREE = 2'h3;

	// ==========================================
	// program counter steps
	localparam logic [15:0] BSF_PC_STEP  = 16'h0001;
	localparam logic [15:0] BSF_SKIP_ONE = 16'h0002;
	localparam logic [15:0] BSF_SKIP_TWO = 16'h0003;

	// ==========================================
	// reset values
	localparam logic BSF_READY_RST = 1'b1;

	// ==========================================
	// operations handled here
	typedef enum logic [4:0] {
		op_frac_mul_signed_unsigned,
		op_pointer_jump,
		op_pointer_call,
		op_compare_skip_equal,
		op_compare_immediate,
		op_skip_reg_bit_clear,
		op_skip_io_bit_clear,
		op_skip_io_bit_set,
		op_branch_flag_set,
		op_branch_flag_clear,
		op_branch_carry_clear,
		op_branch_same_higher,
		op_branch_lower,
		op_branch_signed_ge,
		op_branch_signed_lt,
		op_branch_halfcarry_set,
		op_branch_transfer_set,
		op_branch_transfer_clear,
		op_branch_minus,
		op_branch_plus
	} bsf_op_type;

	// request from decode, one cycle, taken when ready
	typedef struct packed {
		logic        valid;
		bsf_op_type  op;
		logic [7:0]  rd;       // first source value
		logic [7:0]  rr;       // second source value
		logic [7:0]  imm;      // immediate constant
		logic [2:0]  bit_sel;  // register, io or flag bit
		logic [6:0]  offset;   // signed branch offset
		logic [15:0] zptr;     // z pointer pair
		logic [15:0] pc;       // address of this instruction
		logic [7:0]  io_val;   // io register contents
		logic        next_two; // next instruction is two words
		logic [7:0]  status_flags_register;     // status_flags_register now
	} bsf_req_type;

	// results, strobes valid with done
	typedef struct packed {
		logic        done;
		logic [15:0] pc;
		logic [7:0]  status_flags_register;
		logic        status_flags_register_we;
		logic [15:0] prod;
		logic        prod_we;
		logic [15:0] push_addr;
		logic        push_we;
	} bsf_res_type;

	// whole state of the unit
	typedef struct packed {
		logic        ready;
		logic [1:0]  cnt;
		logic        pend_status_flags_register;
		logic        pend_prod;
		logic        pend_push;
		bsf_res_type res;
	} bsf_state_type;

endpackage : bsf_pkg

/* File: bsf_flow_unit.sv */
// execute-stage program flow unit: jumps, calls, skips,
// branches, compare immediate and fractional multiply
// assumes request fields are stable in the cycle they are taken

`timescale 1ns/1ps

// Function
// - fractional mul writes shifted product, Z C, two cycles
// - pointer jump loads pc from z, two cycles
// - pointer call pushes return, loads z, three cycles
// - compare skip equal skips on equal sources
// - compare immediate sets Z N V C H, one cycle
// - skip when register bit clear
// - skip when io bit clear
// - skip when io bit set
// - branch when selected flag set
// - branch when selected flag clear
// - carry clear, same higher, lower branches
// - signed ge branch when N xor V zero
// - signed lt branch when N xor V one
// - half carry set branch
// - transfer flag set and clear branches
// - minus and plus branches on negative flag
module bsf_flow_unit
	import bsf_pkg::*;
(
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	input  wire logic         i_ce,
	// request from decode
	input  wire bsf_req_type  i_req,
	// answer to the core
	output logic              o_ready,
	output bsf_res_type       o_res
);

	// ==========================================
	// state
	bsf_state_type st_r;
	bsf_state_type st_nxt;

	// ==========================================
	// decode helpers
	function automatic logic is_branch(input bsf_op_type op);
		is_branch = (op >= op_branch_flag_set);
	endfunction : is_branch

	function automatic logic is_skip(input bsf_op_type op);
		is_skip = (op == op_compare_skip_equal) ||
			(op == op_skip_reg_bit_clear) ||
			(op == op_skip_io_bit_clear) ||
			(op == op_skip_io_bit_set);
	endfunction : is_skip

	// branch condition from status flags
	function automatic logic br_taken(
		input bsf_op_type op,
		input logic [2:0] sel,
		input logic [7:0] sr
	);
		unique case (op)
			op_branch_flag_set:       br_taken = sr[sel];
			op_branch_flag_clear:     br_taken = !sr[sel];
			op_branch_carry_clear,
			op_branch_same_higher:    br_taken = !sr[BSF_FLAG_C];
			op_branch_lower:          br_taken = sr[BSF_FLAG_C];
			op_branch_signed_ge:
				br_taken = !(sr[BSF_FLAG_N] ^ sr[BSF_FLAG_V]);
			op_branch_signed_lt:
				br_taken = sr[BSF_FLAG_N] ^ sr[BSF_FLAG_V];
			op_branch_halfcarry_set:  br_taken = sr[BSF_FLAG_H];
			op_branch_transfer_set:   br_taken = sr[BSF_FLAG_T];
			op_branch_transfer_clear: br_taken = !sr[BSF_FLAG_T];
			op_branch_minus:          br_taken = sr[BSF_FLAG_N];
			op_branch_plus:           br_taken = !sr[BSF_FLAG_N];
			default:                  br_taken = 1'b0;
		endcase
	endfunction : br_taken

	// ==========================================
	// combinational datapath
	logic        skip_hit;
	logic        taken;
	logic [15:0] pc_inc;
	logic [15:0] br_target;
	logic [15:0] skip_target;
	logic [16:0] mul_full;
	logic [15:0] mul_res;
	logic [7:0]  cmp_diff;
	logic [7:0]  cmp_status_flags_register;
	logic [7:0]  mul_status_flags_register;

	// skip tests on register, io bit or equality
	always_comb begin
		unique case (i_req.op)
			op_compare_skip_equal: skip_hit = (i_req.rd == i_req.rr);
			op_skip_reg_bit_clear: skip_hit = !i_req.rr[i_req.bit_sel];
			op_skip_io_bit_clear:  skip_hit = !i_req.io_val[i_req.bit_sel];
			op_skip_io_bit_set:    skip_hit = i_req.io_val[i_req.bit_sel];
			default:               skip_hit = 1'b0;
		endcase
	end

	assign taken  = br_taken(i_req.op, i_req.bit_sel, i_req.status_flags_register);
	assign pc_inc = i_req.pc + BSF_PC_STEP;

	// offset is sign extended, then plus one
	assign br_target = i_req.pc + {{9{i_req.offset[6]}}, i_req.offset}
		+ BSF_PC_STEP;

	// skipped word count follows next instruction size
	assign skip_target = i_req.pc +
		(i_req.next_two ? BSF_SKIP_TWO : BSF_SKIP_ONE);

	// signed by unsigned; 17 bits hold every product exactly
	// both operands widened to 17 bits so the product is never cut short
	assign mul_full = $signed({{9{i_req.rd[7]}}, i_req.rd}) *
		$signed({9'h000, i_req.rr});
	assign mul_res  = {mul_full[14:0], 1'b0};

	// only Z and C are touched by the multiply
	always_comb begin
		mul_status_flags_register = i_req.status_flags_register;
		mul_status_flags_register[BSF_FLAG_C] = mul_full[15];
		mul_status_flags_register[BSF_FLAG_Z] = (mul_res == 16'h0000);
	end

	// compare immediate: subtract, keep flags only
	assign cmp_diff = i_req.rd - i_req.imm;
	always_comb begin
		cmp_status_flags_register = i_req.status_flags_register;
		cmp_status_flags_register[BSF_FLAG_H] = (!i_req.rd[3] & i_req.imm[3]) |
			(i_req.imm[3] & cmp_diff[3]) |
			(cmp_diff[3] & !i_req.rd[3]);
		cmp_status_flags_register[BSF_FLAG_V] = (i_req.rd[7] & !i_req.imm[7] & !cmp_diff[7]) |
			(!i_req.rd[7] & i_req.imm[7] & cmp_diff[7]);
		cmp_status_flags_register[BSF_FLAG_N] = cmp_diff[7];
		cmp_status_flags_register[BSF_FLAG_Z] = (cmp_diff == 8'h00);
		cmp_status_flags_register[BSF_FLAG_C] = (!i_req.rd[7] & i_req.imm[7]) |
			(i_req.imm[7] & cmp_diff[7]) |
			(cmp_diff[7] & !i_req.rd[7]);
	end

	// ==========================================
	// next state
	always_comb begin
		logic [1:0] cyc;
		cyc = BSF_CYC_ONE;
		st_nxt = st_r;
		// strobes last one cycle only
		st_nxt.res.done    = 1'b0;
		st_nxt.res.status_flags_register_we = 1'b0;
		st_nxt.res.prod_we = 1'b0;
		st_nxt.res.push_we = 1'b0;
		if (st_r.cnt != 2'h0) begin
			// busy: count down, finish on the last cycle
			st_nxt.cnt = st_r.cnt - 2'h1;
			if (st_r.cnt == 2'h1) begin
				st_nxt.ready       = 1'b1;
				st_nxt.res.done    = 1'b1;
				st_nxt.res.status_flags_register_we = st_r.pend_status_flags_register;
				st_nxt.res.prod_we = st_r.pend_prod;
				st_nxt.res.push_we = st_r.pend_push;
			end
		end else if (i_req.valid) begin
			st_nxt.pend_status_flags_register = 1'b0;
			st_nxt.pend_prod = 1'b0;
			st_nxt.pend_push = 1'b0;
			st_nxt.res.pc    = pc_inc;
			unique case (i_req.op)
				op_frac_mul_signed_unsigned: begin
					cyc = BSF_CYC_TWO;
					st_nxt.res.prod  = mul_res;
					st_nxt.res.status_flags_register  = mul_status_flags_register;
					st_nxt.pend_prod = 1'b1;
					st_nxt.pend_status_flags_register = 1'b1;
				end
				op_pointer_jump: begin
					cyc = BSF_CYC_TWO;
					st_nxt.res.pc = i_req.zptr;
				end
				op_pointer_call: begin
					cyc = BSF_CYC_THREE;
					st_nxt.res.pc        = i_req.zptr;
					st_nxt.res.push_addr = pc_inc;
					st_nxt.pend_push     = 1'b1;
				end
				op_compare_immediate: begin
					st_nxt.res.status_flags_register  = cmp_status_flags_register;
					st_nxt.pend_status_flags_register = 1'b1;
				end
				default: begin
					if (is_skip(i_req.op) && skip_hit) begin
						// one extra cycle per skipped word
						cyc = i_req.next_two ? BSF_CYC_THREE
							: BSF_CYC_TWO;
						st_nxt.res.pc = skip_target;
					end else if (is_branch(i_req.op) && taken) begin
						cyc = BSF_CYC_TWO;
						st_nxt.res.pc = br_target;
					end
				end
			endcase
			if (cyc == BSF_CYC_ONE) begin
				st_nxt.res.done    = 1'b1;
				st_nxt.res.status_flags_register_we = st_nxt.pend_status_flags_register;
			end else begin
				st_nxt.ready = 1'b0;
				st_nxt.cnt   = cyc - 2'h1;
			end
		end
	end

	// ==========================================
	// state register, frozen while clock enable is low
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_r       <= '0;
			st_r.ready <= BSF_READY_RST;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_ready = st_r.ready;
	assign o_res   = st_r.res;

	// ==========================================
	// checks; a frozen cycle abandons any sequence in flight
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset || !i_ce);

	logic acc;
	assign acc = i_req.valid && st_r.ready;

	sequence s_two;
		!o_res.done ##1 o_res.done;
	endsequence

	sequence s_three;
		!o_res.done [*2] ##1 o_res.done;
	endsequence

	a_frac_mul_result: assert property (
		acc && i_req.op == op_frac_mul_signed_unsigned |=> s_two
		##0 (o_res.prod_we && o_res.status_flags_register_we &&
		o_res.prod == $past(mul_res, 2)))
		else $error("fractional multiply result or timing wrong");

	a_pointer_jump_pc: assert property (
		acc && i_req.op == op_pointer_jump |=> s_two
		##0 (o_res.pc == $past(i_req.zptr, 2) && !o_res.status_flags_register_we))
		else $error("pointer jump target or timing wrong");

	a_pointer_call_push: assert property (
		acc && i_req.op == op_pointer_call |=> s_three
		##0 (o_res.push_we && o_res.pc == $past(i_req.zptr, 3) &&
		o_res.push_addr == $past(pc_inc, 3)))
		else $error("pointer call push or target wrong");

	a_no_flag_change: assert property (
		acc && (is_skip(i_req.op) || is_branch(i_req.op) ||
		i_req.op == op_pointer_call) |=> !o_res.status_flags_register_we [*3])
		else $error("flow instruction changed flags");

	a_cmp_imm_flags: assert property (
		acc && i_req.op == op_compare_immediate |=> o_res.done &&
		o_res.status_flags_register_we && o_res.status_flags_register[BSF_FLAG_Z] ==
		($past(i_req.rd) == $past(i_req.imm)))
		else $error("compare immediate flags wrong");

	a_skip_two_word: assert property (
		acc && is_skip(i_req.op) && skip_hit && i_req.next_two
		|=> s_three ##0 (o_res.pc == $past(i_req.pc, 3) + BSF_SKIP_TWO))
		else $error("two word skip wrong");

	a_compare_skip_equal_equal_skip: assert property (
		acc && i_req.op == op_compare_skip_equal &&
		i_req.rd == i_req.rr && !i_req.next_two
		|=> s_two ##0 (o_res.pc == $past(i_req.pc, 2) + BSF_SKIP_ONE))
		else $error("equal compare skip wrong");

	a_reg_bit_noskip: assert property (
		acc && i_req.op == op_skip_reg_bit_clear &&
		i_req.rr[i_req.bit_sel] |=> o_res.done &&
		o_res.pc == $past(pc_inc))
		else $error("register bit skip taken when bit set");

	a_io_clear_skip: assert property (
		acc && i_req.op == op_skip_io_bit_clear &&
		!i_req.io_val[i_req.bit_sel] |=> !o_res.done)
		else $error("io bit clear skip not taken");

	a_io_set_skip: assert property (
		acc && i_req.op == op_skip_io_bit_set &&
		!i_req.io_val[i_req.bit_sel] |=> o_res.done)
		else $error("io bit set skip taken wrongly");

	a_branch_taken: assert property (
		acc && is_branch(i_req.op) && taken
		|=> s_two ##0 (o_res.pc == $past(br_target, 2)))
		else $error("taken branch target or timing wrong");

	a_branch_signed: assert property (
		acc && i_req.op == op_branch_signed_ge &&
		(i_req.status_flags_register[BSF_FLAG_N] ^ i_req.status_flags_register[BSF_FLAG_V])
		|=> o_res.done && o_res.pc == $past(pc_inc))
		else $error("signed ge branch taken wrongly");

	a_branch_not_taken: assert property (
		acc && is_branch(i_req.op) && !taken
		|=> o_res.done && o_res.pc == $past(pc_inc) && !o_res.status_flags_register_we)
		else $error("untaken branch target or timing wrong");

	a_call_no_flags: assert property (
		acc && i_req.op == op_pointer_call
		|=> s_three ##0 (!o_res.status_flags_register_we && !o_res.prod_we))
		else $error("pointer call touched flags or product");

endmodule : bsf_flow_unit

/* File: bsf_flow_unit_tb_top.sv */
// self-checking bench of the branch, skip and flow unit
// assumes bsf_pkg and bsf_flow_unit are compiled first

`timescale 1ns/1ps

module bsf_flow_unit_tb_top;
	import bsf_pkg::*;

	// ==========================================
	// clock, reset and ports
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce  = 1'b1;
	bsf_req_type req = '0;
	logic        rdy;
	bsf_res_type res_o;
	int          mismatches = 0;
	int          n_compared = 0;
	int          cycles     = 0;

	// 25 MHz core clock
	always #20 clk = ~clk;

	bsf_flow_unit i_bsf_flow_unit (
		.i_clk   (clk),
		.i_reset (rst),
		.i_ce    (ce),
		.i_req   (req),
		.o_ready (rdy),
		.o_res   (res_o)
	);

	// hang guard: whole run is a few hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end

	// ==========================================
	// shared helpers
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one request; cycles counted from take edge to done edge
	task automatic run(input bsf_req_type r, output int cyc, output bsf_res_type q);
		@(negedge clk);
		r.valid = 1'b1;
		req = r;
		@(negedge clk);
		req.valid = 1'b0;
		cyc = 1;
		// bounded wait of 8 cycles, longer than any legal op
		while (o_res_done() !== 1'b1 && cyc < 8) begin
			@(negedge clk);
			cyc++;
		end
		q = res_o;
	endtask : run

	function automatic logic o_res_done();
		return res_o.done;
	endfunction : o_res_done

	// ==========================================
	// scenarios
	task automatic t_mul();
		bsf_req_type r = '0;
		bsf_res_type q;
		int          cyc;
		r.op   = op_frac_mul_signed_unsigned;
		r.rd   = 8'hC0;
		r.rr   = 8'h80;
		r.status_flags_register = 8'hFE;
		run(r, cyc, q);
		chk("mul cycles", 16'(2), 16'(cyc));
		chk("mul prod", 16'hC000, q.prod);
		chk("mul we", 16'h0001, {15'h0, q.prod_we});
		chk("mul flags", 16'h00FD, {8'h00, q.status_flags_register});
	endtask : t_mul

	task automatic t_jump_call();
		bsf_req_type r = '0;
		bsf_res_type q;
		int          cyc;
		r.op   = op_pointer_jump;
		r.zptr = 16'h1234;
		r.pc   = 16'h0100;
		run(r, cyc, q);
		chk("jump cycles", 16'(2), 16'(cyc));
		chk("jump pc", 16'h1234, q.pc);
		chk("jump flags", 16'h0000, {15'h0, q.status_flags_register_we});
		r.op   = op_pointer_call;
		r.zptr = 16'h2000;
		run(r, cyc, q);
		chk("call cycles", 16'(3), 16'(cyc));
		chk("call pc", 16'h2000, q.pc);
		chk("call push", 16'h0101, q.push_addr);
		chk("call we", 16'h0002, {14'h0, q.push_we, q.status_flags_register_we});
	endtask : t_jump_call

	// borrow, overflow and zero of rd minus k worked out here
	task automatic t_cmp_imm();
		logic [7:0]  a[3] = '{8'h10, 8'h00, 8'h80};
		logic [7:0]  k[3] = '{8'h10, 8'h01, 8'h01};
		bsf_req_type r = '0;
		bsf_res_type q;
		int          cyc;
		logic [7:0]  d;
		logic [7:0]  s;
		int          sd;
		for (int i = 0; i < 3; i++) begin
			r.op   = op_compare_immediate;
			r.rd   = a[i];
			r.imm  = k[i];
			r.status_flags_register = 8'hD0;
			d      = a[i] - k[i];
			s      = 8'hD0;
			s[BSF_FLAG_C] = k[i] > a[i];
			s[BSF_FLAG_Z] = d == 8'h00;
			s[BSF_FLAG_N] = d[7];
			// overflow: signed difference outside the 8-bit range
			sd            = $signed(a[i]) - $signed(k[i]);
			s[BSF_FLAG_V] = (sd < -128) || (sd > 127);
			// half carry: borrow out of the low nibble
			s[BSF_FLAG_H] = k[i][3:0] > a[i][3:0];
			run(r, cyc, q);
			chk("cmp cycles", 16'(1), 16'(cyc));
			chk("cmp flags", {8'h01, s}, {7'h0, q.status_flags_register_we, q.status_flags_register});
		end
	endtask : t_cmp_imm

	// every skip op, skip or not, over one- and two-word targets
	task automatic t_skip();
		bsf_op_type  ops[4] = '{op_compare_skip_equal, op_skip_reg_bit_clear,
			op_skip_io_bit_clear, op_skip_io_bit_set};
		bsf_req_type r = '0;
		bsf_res_type q;
		int          cyc;
		int          e;
		for (int i = 0; i < 4; i++)
			for (int c = 0; c < 2; c++)
				for (int w = 0; w < 2; w++) begin
					r.op       = ops[i];
					r.pc       = 16'h0200;
					r.bit_sel  = 3'h3;
					r.rd       = 8'h5A;
					r.rr       = (i == 0) ? (c ? 8'h5A : 8'h5B) : (c ? 8'hF7 : 8'h08);
					r.io_val   = (i == 3) ? (c ? 8'h08 : 8'hF7) : (c ? 8'hF7 : 8'h08);
					r.next_two = w[0];
					e          = c ? (w ? 3 : 2) : 1;
					run(r, cyc, q);
					chk("skip cycles", 16'(e), 16'(cyc));
					chk("skip pc", 16'h0200 + 16'(e), q.pc);
					chk("skip flags", 16'h0, {15'h0, q.status_flags_register_we});
				end
	endtask : t_skip

	function automatic logic taken(bsf_op_type op, logic [2:0] b, logic [7:0] s);
		case (op)
			op_branch_flag_set:      return s[b];
			op_branch_flag_clear:    return ~s[b];
			op_branch_lower:         return s[BSF_FLAG_C];
			op_branch_signed_ge:     return ~(s[BSF_FLAG_N] ^ s[BSF_FLAG_V]);
			op_branch_signed_lt:     return s[BSF_FLAG_N] ^ s[BSF_FLAG_V];
			op_branch_halfcarry_set: return s[BSF_FLAG_H];
			op_branch_transfer_set:  return s[BSF_FLAG_T];
			op_branch_transfer_clear: return ~s[BSF_FLAG_T];
			op_branch_minus:         return s[BSF_FLAG_N];
			op_branch_plus:          return ~s[BSF_FLAG_N];
			default:                 return ~s[BSF_FLAG_C];
		endcase
	endfunction : taken

	// all branch ops across flag patterns, backward offset of -4
	task automatic t_branch();
		logic [7:0]  sv[4] = '{8'h00, 8'hFF, 8'h04, 8'h29};
		bsf_req_type r = '0;
		bsf_res_type q;
		int          cyc;
		logic        t;
		for (int f = 0; f < 4; f++)
			for (int o = 8; o < 20; o++) begin
				r.op      = bsf_op_type'(o);
				r.status_flags_register    = sv[f];
				r.bit_sel = 3'(o + f);
				r.offset  = 7'h7C;
				r.pc      = 16'h0300;
				t         = taken(r.op, r.bit_sel, r.status_flags_register);
				run(r, cyc, q);
				chk("br cycles", t ? 16'(2) : 16'(1), 16'(cyc));
				chk("br pc", t ? 16'h02FD : 16'h0301, q.pc);
			end
	endtask : t_branch

	// clock enable low in mid instruction must hold the answer back
	task automatic t_freeze();
		bsf_req_type r = '0;
		r.op    = op_pointer_jump;
		r.zptr  = 16'h0ABC;
		r.valid = 1'b1;
		@(negedge clk);
		req = r;
		@(negedge clk);
		req.valid = 1'b0;
		ce        = 1'b0;
		repeat (3) begin
			@(negedge clk);
			chk("freeze done", 16'h0000, {15'h0, res_o.done});
		end
		ce = 1'b1;
		@(negedge clk);
		chk("freeze done", 16'h0001, {15'h0, res_o.done});
		chk("freeze pc", 16'h0ABC, res_o.pc);
	endtask : t_freeze

	// ==========================================
	// closing report
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	// main sequence
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_mul();
		t_jump_call();
		t_cmp_imm();
		t_skip();
		t_branch();
		t_freeze();
		test_done();
	end

endmodule : bsf_flow_unit_tb_top
